// File: csi_burst_pkg.sv
// ============================================================================
// Shared constants and types of the burst sequencer.
// ============================================================================
package csi_burst_pkg;

  // Bits in one serial character.
  localparam int CHAR_BITS = 8;
  // Default width of the remaining character count.
  localparam int COUNT_W = 8;
  // Default address width of the receive buffer (16 bytes).
  localparam int BUF_AW = 4;

  // Bit counter positions for the first and the last bit of a character.
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST  = 3'h7;

  // Event timing selector: buffer-empty or transfer-end.
  localparam logic TIMING_EMPTY = 1'h0;
  localparam logic TIMING_END   = 1'h1;

  // Reset value of the three-wide synchroniser chain: select released, toggles low.
  localparam logic [2:0] SYNC_RESET = 3'h4;
  // Positions inside the synchroniser chain.
  localparam int SYNC_SEL  = 2;
  localparam int SYNC_LOAD = 1;
  localparam int SYNC_DONE = 0;

  // Which handling the next serial transfer event goes to.
  typedef enum logic [2:0] {
    S_IDLE                 = 3'b000,
    burst_rx_next_state    = 3'b001,
    last_rx_complete_state = 3'b010,
    burst_tx_next_state    = 3'b011,
    last_tx_complete_state = 3'b100,
    S_TEARDOWN             = 3'b101
  } handler_sel_t;

endpackage

// File: buf_if.sv
`timescale 1ns/100ps
// ============================================================================
// Port bundle between the sequencer and its receive buffer.
// ============================================================================
interface buf_if #(
  parameter int DW = 8,
  parameter int AW = 4
) (
  input wire logic clk
);
  logic          wr_en;    // Write strobe, one cycle per stored byte.
  logic [AW-1:0] wr_addr;  // Write address.
  logic [DW-1:0] wr_data;  // Byte to store.
  logic [AW-1:0] rd_addr;  // Read address.
  logic [DW-1:0] rd_data;  // Registered read data, one cycle after rd_addr.

  modport mem  (input clk, input wr_en, input wr_addr, input wr_data, input rd_addr,
                output rd_data);
  modport user (input clk, output wr_en, output wr_addr, output wr_data, output rd_addr,
                input rd_data);
endinterface

// File: rx_buffer.sv
`timescale 1ns/100ps
// ============================================================================
// Receive buffer: simple dual-port memory with a registered read port.
// ============================================================================
module rx_buffer #(
  parameter int DW = 8,
  parameter int AW = 4
) (
  buf_if.mem b
);

  // Storage array; contents are undefined after reset, as in any RAM.
  logic [DW-1:0] mem_array [0:(2**AW)-1];
  // Read data register.
  logic [DW-1:0] rd_data_reg;

  // Write and read in one process so a RAM macro can replace it.
  always_ff @(posedge b.clk) begin
    if (b.wr_en) begin
      mem_array[b.wr_addr] <= b.wr_data;
    end
    rd_data_reg <= mem_array[b.rd_addr];
  end

  assign b.rd_data = rd_data_reg;

endmodule

// File: csi_slave_burst_sequencer.sv
`timescale 1ns/100ps
// Function
// - Store every received character in buffer.
// - Count two, or a burst of one, routes to last-receive handling.
// - Busy high when final reception begins.
// - Transmit: decrement count, load next byte.
// - Count one: busy high, switch to end.
// - Then route to last-transmit handling.
// - Last receive: store byte, count zero.
// - Last transmit done: count to zero.
// - Select low runs, high stops serial unit.
// - Deselect: busy high, release pins, clear.
module csi_slave_burst_sequencer
  import csi_burst_pkg::*;
#(
  parameter int CW = COUNT_W,
  parameter int AW = BUF_AW
) (
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic                 sclk,
  input  wire logic                 slave_select_input_n,
  input  wire logic                 serial_data_input,
  output logic                      serial_data_output,
  output logic                      serial_data_oe,
  output logic                      busy_out,
  output logic                      busy_oe,
  input  wire logic                 start,
  input  wire logic                 start_tx,
  input  wire logic [CW-1:0]        burst_len,
  input  wire logic [CHAR_BITS-1:0] tx_data,
  output logic                      tx_take,
  input  wire logic [AW-1:0]        rd_addr,
  output logic [CHAR_BITS-1:0]      rd_data,
  output logic [AW-1:0]             rx_level,
  output logic [CW-1:0]             remaining_char_count,
  output logic                      selected
);

  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);
  localparam logic [CW-1:0] CNT_TWO  = CW'(2);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rst_s1_reg;  // First stage of the reset release.
  logic rst_n;       // Released reset used by the whole design.

  // The release passes two flops so it never lands near an mclk edge.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // ==========================================================================
  // Link side, clocked by the master's serial clock
  // ==========================================================================
  // The serial clock stands still between frames, so the bit counters are
  // ended by the select line itself rather than by any edge of that clock.
  logic                 link_rst;
  logic [CHAR_BITS-1:0] serial_shift_data_reg;  // Byte waiting for the shifter (mclk side).
  logic [2:0]           tx_bit_reg,   tx_bit_next;
  logic [CHAR_BITS-1:0] tx_shift_reg, tx_shift_next;
  logic                 sdo_reg,      sdo_next;
  logic                 load_tog_reg, load_tog_next;
  logic [2:0]           rx_bit_reg,   rx_bit_next;
  logic [CHAR_BITS-1:0] rx_shift_reg, rx_shift_next;
  logic [CHAR_BITS-1:0] rx_byte_reg,  rx_byte_next;
  logic                 done_tog_reg, done_tog_next;

  assign link_rst = slave_select_input_n | ~rst_n;

  // Transmit shifter: the first rising edge of a character takes the waiting
  // byte, which is the buffer-empty moment seen by the sequencer.
  always_comb begin
    tx_bit_next   = 3'(tx_bit_reg + 3'h1);
    load_tog_next = load_tog_reg;
    if (tx_bit_reg == BIT_FIRST) begin
      sdo_next      = serial_shift_data_reg[CHAR_BITS-1];
      tx_shift_next = {serial_shift_data_reg[CHAR_BITS-2:0], 1'b0};
      load_tog_next = ~load_tog_reg;
    end else begin
      sdo_next      = tx_shift_reg[CHAR_BITS-1];
      tx_shift_next = {tx_shift_reg[CHAR_BITS-2:0], 1'b0};
    end
  end

  // Bit position and shifter restart with every selection.
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      tx_bit_reg   <= BIT_FIRST;
      tx_shift_reg <= '0;
      sdo_reg      <= 1'b0;
    end else begin
      tx_bit_reg   <= tx_bit_next;
      tx_shift_reg <= tx_shift_next;
      sdo_reg      <= sdo_next;
    end
  end

  // The toggle survives deselection; clearing it would fake an event.
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      load_tog_reg <= 1'b0;
    end else begin
      load_tog_reg <= load_tog_next;
    end
  end

  // Receive shifter: samples on falling edges, the eighth one ends a character.
  always_comb begin
    rx_bit_next   = 3'(rx_bit_reg + 3'h1);
    rx_shift_next = {rx_shift_reg[CHAR_BITS-2:0], serial_data_input};
    rx_byte_next  = rx_byte_reg;
    done_tog_next = done_tog_reg;
    if (rx_bit_reg == BIT_LAST) begin
      rx_byte_next  = rx_shift_next;
      done_tog_next = ~done_tog_reg;
    end
  end

  // Received byte is held stable for a whole character, long enough for mclk.
  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      rx_bit_reg   <= BIT_FIRST;
      rx_shift_reg <= '0;
    end else begin
      rx_bit_reg   <= rx_bit_next;
      rx_shift_reg <= rx_shift_next;
    end
  end

  // Completion toggle and its data, kept across frames.
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      done_tog_reg <= 1'b0;
      rx_byte_reg  <= '0;
    end else begin
      done_tog_reg <= done_tog_next;
      rx_byte_reg  <= rx_byte_next;
    end
  end

  assign serial_data_output = sdo_reg;

  // ==========================================================================
  // Crossing into mclk
  // ==========================================================================
  logic [2:0] sync1_reg;  // First stages, read only by the second.
  logic [2:0] sync2_reg;  // Settled copies.
  logic [2:0] sync3_reg;  // Delayed copies for edge detection.
  logic       ev_empty;   // Buffer-empty event, one mclk pulse.
  logic       ev_end;     // Transfer-end event, one mclk pulse.
  logic       sel;        // Device currently selected.
  logic       desel_edge; // Select just released.
  logic       sel_out_reg; // Registered copy of the selection for the output pin.

  // Two flops per level or toggle, a third to find the change.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg   <= SYNC_RESET;
      sync2_reg   <= SYNC_RESET;
      sync3_reg   <= SYNC_RESET;
      sel_out_reg <= 1'b0;
    end else begin
      sync1_reg   <= {slave_select_input_n, load_tog_reg, done_tog_reg};
      sync2_reg   <= sync1_reg;
      sync3_reg   <= sync2_reg;
      sel_out_reg <= sel;
    end
  end

  assign ev_empty   = sync2_reg[SYNC_LOAD] ^ sync3_reg[SYNC_LOAD];
  assign ev_end     = sync2_reg[SYNC_DONE] ^ sync3_reg[SYNC_DONE];
  assign sel        = ~sync2_reg[SYNC_SEL];
  assign desel_edge = sync2_reg[SYNC_SEL] & ~sync3_reg[SYNC_SEL];

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  handler_sel_t         next_event_handler_sel_reg, next_event_handler_sel_next;
  logic [CW-1:0]        count_reg,   count_next;
  logic                 timing_reg,  timing_next;
  logic                 busy_reg,    busy_next;
  logic                 busy_oe_reg, busy_oe_next;
  logic                 sdo_oe_reg,  sdo_oe_next;
  logic [CHAR_BITS-1:0] hold_next;
  logic                 take_reg,    take_next;
  logic                 wr_en_reg,   wr_en_next;
  logic [AW-1:0]        wr_ptr_reg,  wr_ptr_next;
  logic [AW-1:0]        wr_addr_reg, wr_addr_next;
  logic [CHAR_BITS-1:0] rd_data_reg;
  logic                 serial_transfer_event;

  // Bundle toward the receive buffer; declared here as the registers read it.
  buf_if #(.DW(CHAR_BITS), .AW(AW)) bus (.clk(mclk));

  // The selected timing decides which synchronised event drives the handler.
  assign serial_transfer_event = (timing_reg == TIMING_END) ? ev_end : ev_empty;

  // Next-state logic; deselection outranks any event of the same cycle.
  always_comb begin
    next_event_handler_sel_next = next_event_handler_sel_reg;
    count_next   = count_reg;
    timing_next  = timing_reg;
    busy_next    = busy_reg;
    busy_oe_next = busy_oe_reg;
    sdo_oe_next  = sdo_oe_reg;
    hold_next    = serial_shift_data_reg;
    take_next    = 1'b0;
    wr_en_next   = 1'b0;
    wr_ptr_next  = wr_ptr_reg;
    wr_addr_next = wr_addr_reg;
    if (desel_edge) begin
      busy_next   = 1'b1;
      sdo_oe_next = 1'b0;
      count_next  = CNT_ZERO;
      timing_next = TIMING_EMPTY;
      next_event_handler_sel_next = S_TEARDOWN;
    end else begin
      case (next_event_handler_sel_reg)
        S_IDLE: begin
          busy_oe_next = sel;
          if (start && sel && (burst_len != CNT_ZERO)) begin
            count_next  = burst_len;
            // Each accepted burst stores from the buffer's first word.
            wr_ptr_next = '0;
            if (start_tx) begin
              hold_next   = tx_data;
              take_next   = 1'b1;
              sdo_oe_next = 1'b1;
              timing_next = TIMING_EMPTY;
              next_event_handler_sel_next = burst_tx_next_state;
            end else begin
              timing_next = TIMING_END;
              busy_next = (burst_len == CNT_ONE);
              next_event_handler_sel_next = (burst_len == CNT_ONE) ?
                  last_rx_complete_state : burst_rx_next_state;
            end
          end
        end
        burst_rx_next_state: begin
          if (serial_transfer_event) begin
            wr_en_next   = 1'b1;
            wr_addr_next = wr_ptr_reg;
            wr_ptr_next  = AW'(wr_ptr_reg + 1'b1);
            count_next   = count_reg - CNT_ONE;
            if (count_reg == CNT_TWO) begin
              busy_next = 1'b1;
              next_event_handler_sel_next = last_rx_complete_state;
            end
          end
        end
        last_rx_complete_state: begin
          if (serial_transfer_event) begin
            wr_en_next   = 1'b1;
            wr_addr_next = wr_ptr_reg;
            wr_ptr_next  = AW'(wr_ptr_reg + 1'b1);
            count_next   = CNT_ZERO;
            busy_next    = 1'b0;
            next_event_handler_sel_next = S_IDLE;
          end
        end
        burst_tx_next_state: begin
          if (serial_transfer_event) begin
            if (count_reg != CNT_ONE) begin
              count_next = count_reg - CNT_ONE;
              hold_next  = tx_data;
              take_next  = 1'b1;
            end else begin
              busy_next   = 1'b1;
              timing_next = TIMING_END;
              next_event_handler_sel_next = last_tx_complete_state;
            end
          end
        end
        last_tx_complete_state: begin
          if (serial_transfer_event) begin
            count_next  = CNT_ZERO;
            busy_next   = 1'b0;
            timing_next = TIMING_EMPTY;
            next_event_handler_sel_next = S_IDLE;
          end
        end
        S_TEARDOWN: begin
          // Busy driven high for one cycle, now released.
          busy_oe_next = 1'b0;
          busy_next    = 1'b0;
          next_event_handler_sel_next = S_IDLE;
        end
        default: begin
          next_event_handler_sel_next = S_IDLE;
        end
      endcase
    end
  end

  // Registers of the sequencer; the write pointer restarts with each burst start.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      next_event_handler_sel_reg <= S_IDLE;
      count_reg             <= '0;
      timing_reg            <= TIMING_EMPTY;
      busy_reg              <= 1'b0;
      busy_oe_reg           <= 1'b0;
      sdo_oe_reg            <= 1'b0;
      serial_shift_data_reg <= '0;
      take_reg              <= 1'b0;
      wr_en_reg             <= 1'b0;
      wr_ptr_reg            <= '0;
      wr_addr_reg           <= '0;
      rd_data_reg           <= '0;
    end else begin
      next_event_handler_sel_reg <= next_event_handler_sel_next;
      count_reg             <= count_next;
      timing_reg            <= timing_next;
      busy_reg              <= busy_next;
      busy_oe_reg           <= busy_oe_next;
      sdo_oe_reg            <= sdo_oe_next;
      serial_shift_data_reg <= hold_next;
      take_reg              <= take_next;
      wr_en_reg             <= wr_en_next;
      wr_ptr_reg            <= wr_ptr_next;
      wr_addr_reg           <= wr_addr_next;
      rd_data_reg           <= bus.rd_data;
    end
  end

  // ==========================================================================
  // Receive buffer
  // ==========================================================================
  logic [CHAR_BITS-1:0] wr_byte_reg;  // Byte captured with its write strobe.

  // Capture the held link byte the cycle the completion event is seen.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_byte_reg <= '0;
    end else if (ev_end) begin
      wr_byte_reg <= rx_byte_reg;
    end
  end

  assign bus.wr_en   = wr_en_reg;
  assign bus.wr_addr = wr_addr_reg;
  assign bus.wr_data = wr_byte_reg;
  assign bus.rd_addr = rd_addr;

  rx_buffer #(.DW(CHAR_BITS), .AW(AW)) u_buf (
    .b (bus.mem)
  );

  assign busy_out             = busy_reg;
  assign busy_oe              = busy_oe_reg;
  assign serial_data_oe       = sdo_oe_reg;
  assign tx_take              = take_reg;
  assign rd_data              = rd_data_reg;
  assign rx_level             = wr_ptr_reg;
  assign remaining_char_count = count_reg;
  assign selected             = sel_out_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_rx_store_each: assert property (
    (next_event_handler_sel_reg == burst_rx_next_state) && ev_end && !desel_edge
    |=> wr_en_reg && (wr_addr_reg == $past(wr_ptr_reg)))
    else $error("Received character not stored.");
  a_rx_last_count: assert property (
    (next_event_handler_sel_reg == last_rx_complete_state) |-> (count_reg == CNT_ONE))
    else $error("Last receive handling without count one.");
  a_rx_busy_final: assert property (
    $rose(next_event_handler_sel_reg == last_rx_complete_state) |-> busy_reg && busy_oe_reg)
    else $error("Busy not raised for final reception.");
  a_tx_decrement: assert property (
    (next_event_handler_sel_reg == burst_tx_next_state) && ev_empty && !desel_edge &&
    (count_reg != CNT_ONE) |=> (count_reg == $past(count_reg) - CNT_ONE) && take_reg)
    else $error("Transmit count or reload wrong.");
  a_tx_switch: assert property (
    (next_event_handler_sel_reg == burst_tx_next_state) && ev_empty && !desel_edge &&
    (count_reg == CNT_ONE) |=> busy_reg && (timing_reg == TIMING_END) && !take_reg)
    else $error("Timing switch at last transmit missing.");
  a_tx_route: assert property (
    (next_event_handler_sel_reg == burst_tx_next_state) && ev_empty && !desel_edge &&
    (count_reg == CNT_ONE) |=> (next_event_handler_sel_reg == last_tx_complete_state))
    else $error("Not routed to last transmit handling.");
  a_rx_final: assert property (
    (next_event_handler_sel_reg == last_rx_complete_state) && ev_end && !desel_edge
    |=> wr_en_reg && (count_reg == CNT_ZERO) && !busy_reg)
    else $error("Final reception not stored or count not cleared.");
  a_tx_final: assert property (
    (next_event_handler_sel_reg == last_tx_complete_state) && ev_end && !desel_edge
    |=> (count_reg == CNT_ZERO) ##1 (next_event_handler_sel_reg == S_IDLE))
    else $error("Final transmit did not clear count.");
  a_desel_teardown: assert property (
    desel_edge |=> busy_reg && busy_oe_reg && !sdo_oe_reg && (count_reg == CNT_ZERO)
    ##1 !busy_oe_reg)
    else $error("Deselect teardown sequence wrong.");
  a_idle_count: assert property (
    (next_event_handler_sel_reg == S_IDLE) |-> (count_reg == CNT_ZERO))
    else $error("Count nonzero while no burst runs.");
  a_unsel_stop: assert property (
    !sel && !$past(sel) |-> !sdo_oe_reg && (next_event_handler_sel_reg inside
    {S_IDLE, S_TEARDOWN}))
    else $error("Serial unit active while deselected.");

  c_rx_burst: cover property (
    (next_event_handler_sel_reg == burst_rx_next_state) ##[1:1000]
    (next_event_handler_sel_reg == last_rx_complete_state) ##[1:1000] wr_en_reg);
  c_tx_burst: cover property (
    take_reg ##[1:1000] take_reg ##[1:1000]
    (next_event_handler_sel_reg == last_tx_complete_state));
  c_deselect_mid: cover property (
    (next_event_handler_sel_reg == burst_rx_next_state) && desel_edge);

endmodule

// File: serial_master_model.sv
`timescale 1ns/100ps
// ============================================================================
// Serial master: selects the slave, clocks characters MSB first.
// ============================================================================
module serial_master_model (
  output logic     sclk,
  output logic     ss_n,
  output logic     sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe,
  input  wire logic busy
);
  // The clock rests low and the select released until a frame begins.
  initial begin
    sclk = 1'h0;
    ss_n = 1'h1;
    sdi  = 1'h0;
  end
  task automatic sel(input logic v);
    ss_n = v;
    #500;
  endtask
  // One character: drive on the rising edge, sample on the falling edge.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'h1;
      sdi  = tx[i];
      #80;
      sclk = 1'h0;
      // A released data pin shows the inverse, so an undriven line never matches.
      rx[i] = sdo_oe ? sdo : ~sdo;
      #80;
    end
    // A stale value is not left standing, so nothing passes by luck.
    sdi = ~tx[0];
    #400;
  endtask
  task automatic wait_busy(output logic idle);
    for (int n = 0; n < 100 && busy === 1'h1; n++) begin
      #10;
    end
    idle = (busy !== 1'h1);
  endtask
endmodule

// File: csi_slave_burst_sequencer_test.sv
`timescale 1ns/100ps
// ============================================================================
// Bench: receive, transmit, refusal and teardown scenarios.
// ============================================================================
module csi_slave_burst_sequencer_test;
  import csi_burst_pkg::*;
  logic       mclk, arst_n, sclk, ss_n, sdi, sdo, sdo_oe, busy_out, busy_oe;
  logic       start, start_tx, tx_take, selected, busy_seen, bus_idle;
  logic [7:0] burst_len, tx_data, rd_data, cnt, rx;
  logic [3:0] rd_addr, rx_level;
  logic [7:0] txq [4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
  int         failures, compares, ti;
  // The system clock runs free at 100 MHz.
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  csi_slave_burst_sequencer u_csi_slave_burst_sequencer (
    .mclk(mclk), .arst_n(arst_n), .sclk(sclk), .slave_select_input_n(ss_n),
    .serial_data_input(sdi), .serial_data_output(sdo), .serial_data_oe(sdo_oe),
    .busy_out(busy_out), .busy_oe(busy_oe), .start(start), .start_tx(start_tx),
    .burst_len(burst_len), .tx_data(tx_data), .tx_take(tx_take), .rd_addr(rd_addr),
    .rd_data(rd_data), .rx_level(rx_level), .remaining_char_count(cnt),
    .selected(selected));
  serial_master_model u_serial_master_model (
    .sclk(sclk), .ss_n(ss_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .busy(busy_out));
  // Offer the next byte once the previous one has been taken.
  always @(posedge mclk) begin
    if (tx_take === 1'h1) begin
      ti <= ti + 1;
      tx_data <= txq[(ti + 1) % 4];
    end
    if (busy_out === 1'h1) begin
      busy_seen <= 1'h1;
    end
  end
  // ==========================================================================
  // Shared tasks.
  // ==========================================================================
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Bounded wait for the count; a hang ends the run.
  task automatic wait_cnt(input logic [7:0] v);
    int n;
    n = 0;
    while (cnt !== v && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (cnt !== v) begin
      failures++;
      tally_and_finish();
    end
  endtask
  task automatic go(input logic tx, input logic [7:0] len);
    @(posedge mclk);
    #1 start = 1'h1;
    start_tx = tx;
    burst_len = len;
    busy_seen = 1'h0;
    @(posedge mclk);
    #1 start = 1'h0;
  endtask
  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  task automatic t_refuse();
    go(1'h0, 8'h03);
    repeat (4) @(posedge mclk);
    check("idle count", cnt, 8'h00);
  endtask
  task automatic t_rx();
    u_serial_master_model.sel(1'h0);
    check("selected", {7'h00, selected}, 8'h01);
    go(1'h0, 8'h03);
    check("rx count", cnt, 8'h03);
    for (int i = 0; i < 3; i++) begin
      u_serial_master_model.xfer(txq[i], rx);
      if (i == 1) begin
        wait_cnt(8'h01);
        check("busy last", {7'h00, busy_out}, 8'h01);
      end
    end
    wait_cnt(8'h00);
    u_serial_master_model.wait_busy(bus_idle);
    check("busy wait", {7'h00, bus_idle}, 8'h01);
    check("busy end", {7'h00, busy_out}, 8'h00);
    check("rx level", {4'h0, rx_level}, 8'h03);
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      #1 rd_addr = i[3:0];
      repeat (2) @(posedge mclk);
      #1 check("rx byte", rd_data, txq[i]);
    end
  endtask
  task automatic t_tx();
    ti = 0;
    tx_data = txq[0];
    go(1'h1, 8'h03);
    check("data oe", {7'h00, sdo_oe}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      u_serial_master_model.xfer(8'h00, rx);
      check("tx byte", rx, txq[i]);
      if (i < 2) begin
        check("tx count", cnt, 8'h02 - i[7:0]);
      end
    end
    wait_cnt(8'h00);
    check("tx busy", {7'h00, busy_seen}, 8'h01);
    check("tx done", cnt, 8'h00);
  endtask
  // A one-character reception starts directly as the final character.
  task automatic t_rx_one();
    go(1'h0, 8'h01);
    check("one busy", {7'h00, busy_out}, 8'h01);
    u_serial_master_model.xfer(8'hC3, rx);
    wait_cnt(8'h00);
    check("one busy end", {7'h00, busy_out}, 8'h00);
    @(posedge mclk);
    #1 rd_addr = 4'h0;
    repeat (2) @(posedge mclk);
    #1 check("one byte", rd_data, 8'hC3);
  endtask
  task automatic t_desel();
    go(1'h0, 8'h04);
    u_serial_master_model.xfer(8'h5A, rx);
    u_serial_master_model.sel(1'h1);
    check("desel count", cnt, 8'h00);
    check("desel busy", {6'h00, busy_seen, busy_oe}, 8'h02);
    check("desel oe", {6'h00, sdo_oe, selected}, 8'h00);
  endtask
  // Reset for five cycles, then run every scenario in turn.
  initial begin
    arst_n = 1'h0;
    start = 1'h0;
    start_tx = 1'h0;
    burst_len = 8'h00;
    tx_data = 8'h00;
    rd_addr = 4'h0;
    busy_seen = 1'h0;
    failures = 0;
    compares = 0;
    ti = 0;
    repeat (5) @(posedge mclk);
    #1 arst_n = 1'h1;
    repeat (5) @(posedge mclk);
    t_refuse();
    t_rx();
    t_tx();
    t_rx_one();
    t_desel();
    tally_and_finish();
  end
endmodule
